// ===== core/ssbr_core.sv
// The address map and register access over AXI4-Lite were decided locally.
`timescale 1ns/100ps
`include "ssbr_map.svh"
module ssbr_core
  import ssbr_pkg::*;
#(
  parameter int ADDR_W = 5
)(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              scl_i,
  output logic                   scl_o,
  output logic                   scl_oe_n,
  input  wire logic              sda_i,
  output logic                   sda_o,
  output logic                   sda_oe_n,
  input  wire logic              rx_byte_done,
  input  wire logic              rx_byte_is_data,
  input  wire logic              addr_match,
  input  wire logic              addr_rw,
  input  wire logic              nack_seen,
  input  wire logic              addr_update,
  output logic                   port_pins_sel,
  output logic                   slew_ctrl_en,
  output logic                   smbus_levels,
  output logic                   spi_sample_end,
  output logic                   spi_launch_idle,
  output logic                   bus_collision_flag,
  output logic                   port_event_flag,
  output logic                   baud_tick
);

  initial
  begin
    if (ADDR_W < 5)
      $error("ADDR_W too small");
  end

  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [1:0]  scl_sync;
    logic [1:0]  sda_sync;
    logic        scl_prev;
    logic        sda_prev;
    logic [7:0]  status;
    logic [7:0]  ctrl1;
    logic [7:0]  reload;
    logic [7:0]  xfer_buffer;
    logic        stop_request;
    logic [7:0]  baud_counter;
    logic [3:0]  bit_cnt;
    logic        half;
    ssbr_phase_t phase;
    logic        aw_held;
    logic        w_held;
    logic [ADDR_W-1:0] awaddr;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        scl_o;
    logic        scl_oe_n;
    logic        sda_oe_n;
    logic        bcl;
    logic        pev;
    logic        tick;
  } ssbr_state_t;

  ssbr_state_t st;
  ssbr_state_t next_st;

  logic scl_s;
  logic sda_s;
  logic en;
  logic two_wire;
  logic count_zero;
  logic wr_go;
  logic [3:0] mode;
  logic [4:0] wa;
  logic [4:0] ra;

  // Five-bit decode so the request register does not alias the status one
  assign wa         = st.awaddr[4:0];
  assign ra         = s_axi_araddr[4:0];
  assign scl_s      = st.scl_sync[1];
  assign sda_s      = st.sda_sync[1];
  assign en         = st.ctrl1[`SSBR_C1_EN];
  assign mode       = st.ctrl1[3:0];
  assign two_wire   = (mode >= `SSBR_M_I2C_S7) && (mode != `SSBR_M_SPI_BRG);
  assign count_zero = (st.baud_counter == 8'h00);
  assign wr_go      = st.aw_held && st.w_held && !st.bvalid;

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb
  begin
    next_st          = st;
    next_st.scl_sync = {st.scl_sync[0], scl_i};
    next_st.sda_sync = {st.sda_sync[0], sda_i};
    next_st.scl_prev = scl_s;
    next_st.sda_prev = sda_s;
    next_st.tick     = 1'b0;
    next_st.bcl      = 1'b0;
    next_st.pev      = 1'b0;

    // Bus conditions seen on the lines
    if (scl_s && st.scl_prev && st.sda_prev && !sda_s)
    begin
      next_st.status[`SSBR_ST_START] = 1'b1;
      next_st.status[`SSBR_ST_STOP]  = 1'b0;
    end
    if (scl_s && st.scl_prev && !st.sda_prev && sda_s)
    begin
      next_st.status[`SSBR_ST_STOP]  = 1'b1;
      next_st.status[`SSBR_ST_START] = 1'b0;
    end

    // Slave side status from the shifter
    if (rx_byte_done)
    begin
      next_st.status[`SSBR_ST_DA] = rx_byte_is_data;
      if (st.status[`SSBR_ST_BF])
        next_st.ctrl1[`SSBR_C1_OV] = (mode != `SSBR_M_SPI_D4) && (mode != `SSBR_M_SPI_D16)
          && (mode != `SSBR_M_SPI_D64) && (mode != `SSBR_M_SPI_BRG)
          && (mode != `SSBR_M_SPI_TMR);
      else
        next_st.status[`SSBR_ST_BF] = 1'b1;
    end
    if (addr_match && mode != `SSBR_M_I2C_MST)
      next_st.status[`SSBR_ST_RW] = addr_rw;
    else if (nack_seen && mode != `SSBR_M_I2C_MST)
      next_st.status[`SSBR_ST_RW] = 1'b0;
    if (addr_update && (mode == `SSBR_M_I2C_S10 || mode == `SSBR_M_I2C_S10I))
      next_st.status[`SSBR_ST_UA] = 1'b1;

    // Baud counter
    if (st.phase != SSBR_IDLE && !count_zero)
      next_st.baud_counter = st.baud_counter - 8'h01;

    unique case (st.phase)
      SSBR_IDLE:
      begin
        next_st.sda_oe_n = 1'b1;
      end
      SSBR_STOP_SDA_LOW:
      begin
        next_st.sda_oe_n = 1'b0;
        if (!sda_s)
        begin
          next_st.scl_oe_n = 1'b1;
          next_st.phase    = SSBR_STOP_SCL_REL;
        end
      end
      SSBR_STOP_SCL_REL:
      begin
        if (scl_s)
        begin
          next_st.baud_counter = st.reload;
          next_st.phase        = SSBR_STOP_COUNT;
        end
      end
      SSBR_STOP_COUNT:
      begin
        if (!scl_s)
          next_st.bcl = 1'b1;
        else if (count_zero)
        begin
          next_st.sda_oe_n     = 1'b1;
          next_st.baud_counter = st.reload;
          next_st.phase        = SSBR_STOP_SDA_REL;
        end
      end
      SSBR_STOP_SDA_REL:
      begin
        if (!scl_s && !sda_s)
          next_st.bcl = 1'b1;
        else if (count_zero)
        begin
          if (!sda_s)
            next_st.bcl = 1'b1;
          else
          begin
            next_st.baud_counter = st.reload;
            next_st.phase        = SSBR_STOP_TAIL;
          end
        end
      end
      SSBR_STOP_TAIL:
      begin
        if (count_zero)
        begin
          next_st.stop_request = 1'b0;
          next_st.pev          = 1'b1;
          next_st.phase        = SSBR_IDLE;
        end
      end
      SSBR_XFER:
      begin
        if (count_zero)
        begin
          next_st.tick         = 1'b1;
          next_st.baud_counter = st.reload;
          next_st.half         = !st.half;
          if (two_wire)
            next_st.scl_oe_n = st.half;
          else
            next_st.scl_o = !st.scl_o;
          if (st.half)
            next_st.bit_cnt = st.bit_cnt + 4'h1;
          if (st.half && st.bit_cnt == 4'h7)
          begin
            next_st.phase               = SSBR_IDLE;
            next_st.status[`SSBR_ST_BF] = 1'b0;
          end
        end
      end
      default:
      begin
        next_st.phase = SSBR_IDLE;
      end
    endcase

    if (next_st.bcl)
    begin
      next_st.phase        = SSBR_IDLE;
      next_st.stop_request = 1'b0;
      next_st.sda_oe_n     = 1'b1;
      next_st.scl_oe_n     = 1'b1;
      next_st.status[`SSBR_ST_BF] = 1'b0;
    end

    // AXI write channel
    if (s_axi_awvalid && !st.aw_held)
    begin
      next_st.aw_held = 1'b1;
      next_st.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !st.w_held)
    begin
      next_st.w_held = 1'b1;
      next_st.wdata  = s_axi_wdata;
      next_st.wstrb  = s_axi_wstrb;
    end
    if (wr_go)
    begin
      next_st.aw_held = 1'b0;
      next_st.w_held  = 1'b0;
      next_st.bvalid  = 1'b1;
      next_st.bresp   = `SSBR_RESP_OKAY;
      if (st.wstrb[0])
      begin
        unique case (wa)
          `SSBR_ADDR_STATUS:
          begin
            next_st.status[7:6] = st.wdata[7:6];
          end
          `SSBR_ADDR_CTRL1:
          begin
            next_st.ctrl1[5:0] = st.wdata[5:0];
            if (!st.wdata[`SSBR_C1_WRITE_COLLISION] && !next_st.ctrl1[`SSBR_C1_WRITE_COLLISION])
              next_st.ctrl1[`SSBR_C1_WRITE_COLLISION] = 1'b0;
            else if (!st.wdata[`SSBR_C1_WRITE_COLLISION])
              next_st.ctrl1[`SSBR_C1_WRITE_COLLISION] = 1'b0;
            if (!st.wdata[`SSBR_C1_OV] && !(rx_byte_done && st.status[`SSBR_ST_BF]))
              next_st.ctrl1[`SSBR_C1_OV] = 1'b0;
            if (!st.wdata[`SSBR_C1_EN])
            begin
              next_st.status[`SSBR_ST_STOP]  = 1'b0;
              next_st.status[`SSBR_ST_START] = 1'b0;
              next_st.phase                  = SSBR_IDLE;
            end
          end
          `SSBR_ADDR_RELOAD:
          begin
            next_st.reload = st.wdata[7:0];
            next_st.status[`SSBR_ST_UA] = 1'b0;
          end
          `SSBR_ADDR_XFER:
          begin
            if (st.phase != SSBR_IDLE || st.stop_request)
              next_st.ctrl1[`SSBR_C1_WRITE_COLLISION] = 1'b1;
            else if (en)
            begin
              next_st.xfer_buffer  = st.wdata[7:0];
              next_st.baud_counter = st.reload;
              next_st.bit_cnt      = 4'h0;
              next_st.half         = 1'b0;
              next_st.phase        = SSBR_XFER;
              next_st.status[`SSBR_ST_BF] = two_wire;
            end
          end
          `SSBR_ADDR_REQ:
          begin
            next_st.bresp = `SSBR_RESP_OKAY;
          end
          default:
          begin
            next_st.bresp = `SSBR_RESP_SLVERR;
          end
        endcase
      end
      if (wa == `SSBR_ADDR_REQ && st.wstrb[0]
          && st.wdata[`SSBR_RQ_STOP] && st.phase == SSBR_IDLE && en
          && mode == `SSBR_M_I2C_MST)
      begin
        next_st.stop_request = 1'b1;
        next_st.phase        = SSBR_STOP_SDA_LOW;
      end
    end
    if (st.bvalid && s_axi_bready)
      next_st.bvalid = 1'b0;

    // AXI read channel
    if (s_axi_arvalid && !st.rvalid)
    begin
      next_st.rvalid = 1'b1;
      next_st.rresp  = `SSBR_RESP_OKAY;
      next_st.rdata  = 32'h0000_0000;
      unique case (ra)
        `SSBR_ADDR_STATUS: next_st.rdata[7:0] = {st.status[7:3],
          (mode == `SSBR_M_I2C_MST) ? (st.phase == SSBR_XFER) : st.status[2],
          st.status[1:0]};
        `SSBR_ADDR_CTRL1:  next_st.rdata[7:0] = st.ctrl1;
        `SSBR_ADDR_RELOAD: next_st.rdata[7:0] = st.reload;
        `SSBR_ADDR_XFER:
        begin
          next_st.rdata[7:0]          = st.xfer_buffer;
          next_st.status[`SSBR_ST_BF] = rx_byte_done; // Read empties buffer
        end
        `SSBR_ADDR_REQ:
          next_st.rdata[0] = st.stop_request;
        default: next_st.rresp = `SSBR_RESP_SLVERR;
      endcase
    end
    if (st.rvalid && s_axi_rready)
      next_st.rvalid = 1'b0;

    if (!en)
    begin
      next_st.scl_oe_n = 1'b1;
      next_st.sda_oe_n = 1'b1;
      next_st.scl_o    = st.ctrl1[`SSBR_C1_CKP];
    end
    else if (!two_wire && st.phase == SSBR_IDLE)
      next_st.scl_o = st.ctrl1[`SSBR_C1_CKP];
    else if (two_wire && mode != `SSBR_M_I2C_MST && st.phase == SSBR_IDLE)
      next_st.scl_oe_n = st.ctrl1[`SSBR_C1_CKP];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st          <= '0;
      st.status   <= `SSBR_RST_STATUS;
      st.ctrl1    <= `SSBR_RST_CTRL1;
      st.reload   <= `SSBR_RST_RELOAD;
      st.scl_sync <= 2'b11;
      st.sda_sync <= 2'b11;
      st.scl_prev <= 1'b1;
      st.sda_prev <= 1'b1;
      st.scl_oe_n <= 1'b1;
      st.sda_oe_n <= 1'b1;
      st.phase    <= SSBR_IDLE;
    end
    else
      st <= next_st;
  end

  // ==========================================================
  // Outputs
  // ==========================================================
  assign s_axi_awready      = !st.aw_held;
  assign s_axi_wready       = !st.w_held;
  assign s_axi_bvalid       = st.bvalid;
  assign s_axi_bresp        = st.bresp;
  assign s_axi_arready      = !st.rvalid;
  assign s_axi_rvalid       = st.rvalid;
  assign s_axi_rdata        = st.rdata;
  assign s_axi_rresp        = st.rresp;
  assign scl_o              = st.scl_o;
  assign scl_oe_n           = st.scl_oe_n;
  assign sda_o              = 1'b0;
  assign sda_oe_n           = st.sda_oe_n;
  assign port_pins_sel      = st.ctrl1[`SSBR_C1_EN];
  assign slew_ctrl_en       = !st.status[`SSBR_ST_SMP];
  assign smbus_levels       = st.status[`SSBR_ST_CKE];
  assign spi_sample_end     = st.status[`SSBR_ST_SMP];
  assign spi_launch_idle    = st.status[`SSBR_ST_CKE];
  assign bus_collision_flag = st.bcl;
  assign port_event_flag    = st.pev;
  assign baud_tick          = st.tick;
endmodule

// ===== core/ssbr_map.svh
`ifndef SSBR_MAP_SVH
`define SSBR_MAP_SVH
// Register byte addresses
`define SSBR_ADDR_STATUS   5'h00
`define SSBR_ADDR_CTRL1    5'h04
`define SSBR_ADDR_RELOAD   5'h08
`define SSBR_ADDR_XFER     5'h0c
`define SSBR_ADDR_REQ      5'h10
// Reset values
`define SSBR_RST_STATUS    8'h00
`define SSBR_RST_CTRL1     8'h00
`define SSBR_RST_RELOAD    8'h00
// Status fields
`define SSBR_ST_SMP        7
`define SSBR_ST_CKE        6
`define SSBR_ST_DA         5
`define SSBR_ST_STOP       4
`define SSBR_ST_START      3
`define SSBR_ST_RW         2
`define SSBR_ST_UA         1
`define SSBR_ST_BF         0
// Control one fields
`define SSBR_C1_WRITE_COLLISION       7
`define SSBR_C1_OV         6
`define SSBR_C1_EN         5
`define SSBR_C1_CKP        4
// Request register fields
`define SSBR_RQ_STOP       0
// Mode codes
`define SSBR_M_SPI_BRG     4'ha
`define SSBR_M_I2C_MST     4'h8
`define SSBR_M_SPI_SLV0    4'h4
`define SSBR_M_SPI_SLV1    4'h5
`define SSBR_M_SPI_D4      4'h0
`define SSBR_M_SPI_D16     4'h1
`define SSBR_M_SPI_D64     4'h2
`define SSBR_M_SPI_TMR     4'h3
`define SSBR_M_I2C_S7      4'h6
`define SSBR_M_I2C_S10     4'h7
`define SSBR_M_I2C_FW      4'hb
`define SSBR_M_I2C_S7I     4'he
`define SSBR_M_I2C_S10I    4'hf
// AXI responses
`define SSBR_RESP_OKAY     2'b00
`define SSBR_RESP_SLVERR   2'b10
`endif

// ===== core/ssbr_pkg.sv
package ssbr_pkg;
  typedef enum logic [2:0] {
    SSBR_IDLE,
    SSBR_STOP_SDA_LOW,
    SSBR_STOP_SCL_REL,
    SSBR_STOP_COUNT,
    SSBR_STOP_SDA_REL,
    SSBR_STOP_TAIL,
    SSBR_XFER
  } ssbr_phase_t;
endpackage

// ===== verification/ssbr_bus_peer.sv
`timescale 1ns/100ps
module ssbr_bus_peer (
  input  wire logic scl_oe_n,
  input  wire logic sda_oe_n,
  input  wire logic sda_o,
  input  wire logic hold_scl,
  input  wire logic hold_sda,
  output logic      scl_i,
  output logic      sda_i
);
  // ==========================================
  // Open-drain lines with pull-ups
  // Hold inputs play a stretching or rival peer
  assign scl_i = scl_oe_n & ~hold_scl;
  assign sda_i = (sda_oe_n | sda_o) & ~hold_sda;
endmodule

// ===== verification/ssbr_properties.sv
`timescale 1ns/100ps
module ssbr_properties (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        scl_i,
  input wire logic        scl_oe_n,
  input wire logic        sda_oe_n,
  input wire logic        port_pins_sel,
  input wire logic        bus_collision_flag,
  input wire logic        port_event_flag
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);
  // ==========================================
  // Stop phases
  sequence s_stop_hold;
    scl_oe_n && $past(scl_oe_n) && !sda_oe_n;
  endsequence
  sequence s_lines_free;
    (scl_oe_n && sda_oe_n) [*2];
  endsequence
  // ==========================================
  // Checks
  a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
  a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
  a_scl_steal: assert property (
    s_stop_hold ##0 $fell(scl_i) |-> ##[0:4] bus_collision_flag)
    else $error("clock stolen without collision");
  a_collide_free: assert property (
    bus_collision_flag |-> ##[0:1] s_lines_free) else $error("lines kept after collision");
  a_off_no_drive: assert property (
    !port_pins_sel ##1 !port_pins_sel |-> scl_oe_n && sda_oe_n)
    else $error("pins driven while disabled");
  a_event_pulse: assert property (
    port_event_flag |=> !port_event_flag) else $error("event flag too long");
  a_abort_quiet: assert property (
    bus_collision_flag |-> !port_event_flag [*8]) else $error("stop completed after collision");
  a_release_order: assert property (
    port_pins_sel && $rose(sda_oe_n) |-> ($past(scl_oe_n) && $past(scl_i))
    or ##[0:2] bus_collision_flag) else $error("data freed before clock high");
endmodule

bind ssbr_core ssbr_properties u_props (.*);

// ===== verification/tb.sv
`timescale 1ns/100ps
`include "ssbr_map.svh"
module tb;
  localparam logic [4:0] REQ_A = 5'h10;
  localparam logic [7:0] RLD   = 8'h10;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h0;
  logic [4:0]  s_axi_araddr = 5'h0;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'h0;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        rx_byte_done = 1'b0, rx_byte_is_data = 1'b0, addr_match = 1'b0;
  logic        addr_rw = 1'b0, nack_seen = 1'b0, addr_update = 1'b0;
  logic        hold_scl = 1'b0, hold_sda = 1'b0, got;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0] s_axi_rdata, rdat;
  logic        scl_i, scl_o, scl_oe_n, sda_i, sda_o, sda_oe_n, baud_tick;
  logic        port_pins_sel, slew_ctrl_en, smbus_levels, spi_sample_end, spi_launch_idle;
  logic        bus_collision_flag, port_event_flag;
  int          bad_count = 0, num_checks = 0, ev_n = 0, bc_n = 0, tk_n = 0;
  int          cyc = 0, last_tk = 0, gap = 0;

  ssbr_core #(.ADDR_W(5)) u_dut (.*);
  ssbr_bus_peer u_peer (.*);

  always #20 aclk = ~aclk;

  // ==========================================
  // Event counters
  always @(posedge aclk)
  begin
    cyc <= cyc + 1;
    if (port_event_flag) ev_n <= ev_n + 1;
    if (bus_collision_flag) bc_n <= bc_n + 1;
    if (baud_tick)
    begin
      tk_n <= tk_n + 1;
      gap <= cyc - last_tk;
      last_tk <= cyc;
    end
  end

  // ==========================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] want);
    num_checks++;
    if (seen !== want)
    begin
      bad_count++;
      $display("wrong value at %0t: saw %h want %h", $time, seen, want);
    end
  endtask

  task automatic bus(input logic w, input logic [4:0] a, input logic [7:0] d);
    int n;
    n = 0;
    got = 1'b0;
    if (w)
    begin
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_wstrb <= 4'h1;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
    end
    else
    begin
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
    end
    while (!got && n < 100)
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (w ? s_axi_bvalid : s_axi_rvalid)
      begin
        got = 1'b1;
        rsp = w ? s_axi_bresp : s_axi_rresp;
        rdat = s_axi_rdata;
      end
    end
    if (!got) bad_count++;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask

  task automatic rchk(input logic [4:0] a, input logic [31:0] want);
    bus(1'b0, a, 8'h0);
    check(rdat, want);
  endtask

  task automatic pulse(input logic [5:0] p);
    {rx_byte_done, rx_byte_is_data, addr_match, addr_rw, nack_seen, addr_update} <= p;
    @(posedge aclk);
    {rx_byte_done, rx_byte_is_data, addr_match, addr_rw, nack_seen, addr_update} <= 6'h0;
    @(posedge aclk);
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  // ==========================================
  // Scenarios
  task automatic t_reset();
    rchk(`SSBR_ADDR_STATUS, 32'h0);
    rchk(`SSBR_ADDR_CTRL1, 32'h0);
    rchk(`SSBR_ADDR_RELOAD, 32'h0);
    bus(1'b0, 5'h14, 8'h0);
    check(rsp, `SSBR_RESP_SLVERR);
    check({port_pins_sel, scl_oe_n, sda_oe_n}, 3'b011);
  endtask

  task automatic t_modes();
    logic [3:0] m [13] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
                           4'h7, 4'h8, 4'ha, 4'hb, 4'he, 4'hf};
    foreach (m[i])
    begin
      bus(1'b1, `SSBR_ADDR_CTRL1, {4'h2, m[i]});
      rchk(`SSBR_ADDR_CTRL1, {28'h2, m[i]});
      check(port_pins_sel, 1'b1);
    end
  endtask

  task automatic t_phase();
    int t0;
    bus(1'b1, `SSBR_ADDR_CTRL1, 8'h28);
    bus(1'b1, `SSBR_ADDR_STATUS, 8'hc0);
    check({slew_ctrl_en, smbus_levels}, 2'b01);
    bus(1'b1, `SSBR_ADDR_STATUS, 8'h00);
    check({slew_ctrl_en, smbus_levels}, 2'b10);
    bus(1'b1, `SSBR_ADDR_RELOAD, 8'h03);
    bus(1'b1, `SSBR_ADDR_CTRL1, 8'h3a);
    bus(1'b1, `SSBR_ADDR_STATUS, 8'hc0);
    check({spi_sample_end, spi_launch_idle, scl_o}, 3'b111);
    t0 = tk_n;
    bus(1'b1, `SSBR_ADDR_XFER, 8'ha5);
    repeat (20) @(posedge aclk);
    check(tk_n != t0, 1'b1);
    repeat (400) @(posedge aclk);
    check(gap, 32'd4);
    t0 = tk_n;
    repeat (40) @(posedge aclk);
    check(tk_n - t0, 32'h0);
    check(scl_o, 1'b1);
    bus(1'b1, `SSBR_ADDR_CTRL1, 8'h2a);
    check(scl_o, 1'b0);
  endtask

  task automatic t_stop(input int kind);
    int e0, b0, n, k;
    e0 = ev_n;
    b0 = bc_n;
    n = 0;
    k = 0;
    hold_sda <= (kind == 1);
    bus(1'b1, REQ_A, 8'h01);
    bus(1'b1, `SSBR_ADDR_XFER, 8'h55);
    while (ev_n == e0 && bc_n == b0 && n < 600)
    begin
      @(posedge aclk);
      n++;
      // Steal the clock midway through the count, after it was seen high
      if (kind == 2 && !sda_oe_n)
      begin
        k++;
        if (k == 8) hold_scl <= 1'b1;
      end
    end
    hold_scl <= 1'b0;
    hold_sda <= 1'b0;
    check(ev_n - e0, kind == 0);
    check(bc_n - b0, kind != 0);
    check({scl_oe_n, sda_oe_n}, 2'b11);
    repeat (3) @(posedge aclk);
    rchk(REQ_A, 32'h0);
    rchk(`SSBR_ADDR_CTRL1, 32'ha8);
    bus(1'b1, `SSBR_ADDR_CTRL1, 8'h28);
    rchk(`SSBR_ADDR_CTRL1, 32'h28);
    if (kind == 0)
    begin
      rchk(`SSBR_ADDR_STATUS, 32'h10);
    end
  endtask

  task automatic t_slave();
    bus(1'b1, `SSBR_ADDR_CTRL1, 8'h26);
    pulse(6'b001100);
    rchk(`SSBR_ADDR_STATUS, 32'h04);
    pulse(6'b110000);
    rchk(`SSBR_ADDR_STATUS, 32'h25);
    pulse(6'b110000);
    rchk(`SSBR_ADDR_CTRL1, 32'h66);
    bus(1'b0, `SSBR_ADDR_XFER, 8'h0);
    rchk(`SSBR_ADDR_STATUS, 32'h24);
    bus(1'b1, `SSBR_ADDR_CTRL1, 8'h27);
    pulse(6'b000001);
    bus(1'b0, `SSBR_ADDR_STATUS, 8'h0);
    check(rdat[1], 1'b1);
  endtask

  // ==========================================
  // Main sequence and watchdog
  initial
  begin
    repeat (20000) @(posedge aclk);
    bad_count++;
    tally_and_finish();
  end

  initial
  begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_modes();
    t_phase();
    bus(1'b1, `SSBR_ADDR_STATUS, 8'h00);
    bus(1'b1, `SSBR_ADDR_RELOAD, RLD);
    bus(1'b1, `SSBR_ADDR_CTRL1, 8'h28);
    t_stop(0);
    t_stop(1);
    t_stop(2);
    bus(1'b1, `SSBR_ADDR_CTRL1, 8'h08);
    rchk(`SSBR_ADDR_STATUS, 32'h0);
    check(port_pins_sel, 1'b0);
    t_slave();
    tally_and_finish();
  end
endmodule
